// File: hw/psfc_cfg_regs.sv
`timescale 1ns/1ns
// Functional notes
// - Bit 7 of the sleep register picks the analog rail: 0 external, 1 on-chip regulator (only with 3.3 V supply).
// - Sleep register bits 4-3 set the reference quick-charge time: 3.5, 10, 50 or 100 ms.
// - Sleep register bit 2 set makes the device answer the fixed target address 1001100.
// - Sleep register bit 0 is active-low sleep, resets to 0 so the device starts asleep.
// - Shutdown register bits 5-4 set the input-capacitor quick-charge time: 2.5, 12.5, 25 or 50 ms.
// - Format bits 7-6 select TDM, two-channel or left-justified; code 3 is reserved and unused.
// - Format bits 5-4 select 16, 20, 24 or 32 bit words, resetting to 32.
// - Format bit 3 inverts frame sync polarity and bit 2 inverts bit clock polarity.
// - Format bit 1 moves data launch half a bit clock later, to the opposite edge.
// - Format bit 0 makes unused bit clock cycles high impedance instead of zero.
module psfc_cfg_regs (
   input wire logic mclk_i,                   // 10 MHz clock
   input wire logic resetn_i,                 // async reset, low
   input wire psfc_pkg::psfc_req_t req_i,     // register access from control bus
   input wire logic [6:0] target_addr_i,      // address seen on control bus
   output logic [7:0] rdata_o,                // read data, valid cycle after read
   output logic bcast_match_o,                // address hit on broadcast address
   output psfc_pkg::psfc_cfg_t cfg_o,         // decoded configuration
   output logic [1:0] reference_quick_charge_time_o,  // raw code
   output logic [1:0] input_cap_quick_charge_time_o,  // raw code
   output logic sleep_n_o,                    // device awake
   output logic ref_charging_o,               // reference quick charge running
   output logic incap_charging_o              // input cap quick charge running
);
   typedef struct packed {
      logic [7:0] sleep_cfg;
      logic [7:0] shutdown_config;
      logic [7:0] fmt_cfg;
      logic [7:0] rdata;
      logic bcast_match;
      psfc_pkg::psfc_cfg_t cfg;
      logic ref_chg;
      logic incap_chg;
      logic wake_pulse;
   } psfc_state_t;

   psfc_state_t s_q, s_d;
   logic ref_busy;
   logic incap_busy;

   always_comb begin
      s_d = s_q;
      s_d.wake_pulse = 1'b0;
      if (req_i.write) begin
         unique case (req_i.addr)
            psfc_pkg::SLEEP_SUPPLY_CONFIG_ADDR: begin
               s_d.sleep_cfg = (req_i.wdata & psfc_pkg::SLEEP_SUPPLY_CONFIG_WMASK)
                  | (psfc_pkg::SLEEP_SUPPLY_CONFIG_RST & ~psfc_pkg::SLEEP_SUPPLY_CONFIG_WMASK);
               // quick charge of the reference starts when leaving sleep
               s_d.wake_pulse = req_i.wdata[psfc_pkg::AWAKE_BIT]
                  & ~s_q.sleep_cfg[psfc_pkg::AWAKE_BIT];
            end
            psfc_pkg::SHUTDOWN_CONFIG_ADDR: begin
               // reserved bits 3-0 keep what software wrote; bits 7-6 hold their reset value
               s_d.shutdown_config = (req_i.wdata & psfc_pkg::SHUTDOWN_CONFIG_WMASK)
                  | (psfc_pkg::SHUTDOWN_CONFIG_RST & ~psfc_pkg::SHUTDOWN_CONFIG_WMASK);
            end
            psfc_pkg::SERIAL_FORMAT_CONFIG_ADDR: begin
               s_d.fmt_cfg = req_i.wdata;
            end
            default: begin
            end
         endcase
      end
      if (req_i.read) begin
         unique case (req_i.addr)
            psfc_pkg::SLEEP_SUPPLY_CONFIG_ADDR: s_d.rdata = s_q.sleep_cfg;
            psfc_pkg::SHUTDOWN_CONFIG_ADDR: s_d.rdata = s_q.shutdown_config;
            psfc_pkg::SERIAL_FORMAT_CONFIG_ADDR: s_d.rdata = s_q.fmt_cfg;
            default: s_d.rdata = 8'h00;
         endcase
      end
      s_d.bcast_match = s_q.sleep_cfg[psfc_pkg::BCAST_EN_BIT]
         && (target_addr_i == psfc_pkg::BCAST_ADDR);
      s_d.cfg.analog_rail_source_sel = s_q.sleep_cfg[psfc_pkg::RAIL_SEL_BIT];
      s_d.cfg.broadcast_address_enable = s_q.sleep_cfg[psfc_pkg::BCAST_EN_BIT];
      s_d.cfg.awake = s_q.sleep_cfg[psfc_pkg::AWAKE_BIT];
      s_d.cfg.serial_protocol_select =
         psfc_pkg::psfc_proto_t'(s_q.fmt_cfg[psfc_pkg::PROTO_LSB +: 2]);
      unique case (s_q.fmt_cfg[psfc_pkg::WLEN_LSB +: 2])
         2'h0: s_d.cfg.serial_word_bits = 6'h10;
         2'h1: s_d.cfg.serial_word_bits = 6'h14;
         2'h2: s_d.cfg.serial_word_bits = 6'h18;
         2'h3: s_d.cfg.serial_word_bits = 6'h20;
      endcase
      s_d.cfg.frame_sync_polarity = s_q.fmt_cfg[psfc_pkg::FRAME_SYNC_POLARITY_BIT];
      s_d.cfg.bit_clock_polarity = s_q.fmt_cfg[psfc_pkg::BIT_CLOCK_POLARITY_BIT];
      s_d.cfg.tx_late_edge = s_q.fmt_cfg[psfc_pkg::TX_EDGE_BIT];
      s_d.cfg.tx_fill_hiz = s_q.fmt_cfg[psfc_pkg::TX_FILL_BIT];
      s_d.ref_chg = ref_busy;
      s_d.incap_chg = incap_busy;
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_q <= '0;
         s_q.sleep_cfg <= psfc_pkg::SLEEP_SUPPLY_CONFIG_RST;
         s_q.shutdown_config <= psfc_pkg::SHUTDOWN_CONFIG_RST;
         s_q.fmt_cfg <= psfc_pkg::SERIAL_FORMAT_CONFIG_RST;
         s_q.cfg.serial_word_bits <= 6'h20;
      end else begin
         s_q <= s_d;
      end
   end

   // reference cap charge on wake
   psfc_qchg_timer #(
      .CYC0(psfc_pkg::REF_QCHG_CYC0),
      .CYC1(psfc_pkg::REF_QCHG_CYC1),
      .CYC2(psfc_pkg::REF_QCHG_CYC2),
      .CYC3(psfc_pkg::REF_QCHG_CYC3)
   ) u_ref_timer (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .start_i(s_q.wake_pulse),
      .sel_i(s_q.sleep_cfg[psfc_pkg::REF_QCHG_LSB +: 2]),
      .busy_o(ref_busy)
   );

   // input coupling cap charge on wake
   psfc_qchg_timer #(
      .CYC0(psfc_pkg::INPUT_CAP_QUICK_CHARGE_TIME_CYC0),
      .CYC1(psfc_pkg::INPUT_CAP_QUICK_CHARGE_TIME_CYC1),
      .CYC2(psfc_pkg::INPUT_CAP_QUICK_CHARGE_TIME_CYC2),
      .CYC3(psfc_pkg::INPUT_CAP_QUICK_CHARGE_TIME_CYC3)
   ) u_incap_timer (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .start_i(s_q.wake_pulse),
      .sel_i(s_q.shutdown_config[psfc_pkg::INPUT_CAP_QUICK_CHARGE_TIME_LSB +: 2]),
      .busy_o(incap_busy)
   );

   assign rdata_o = s_q.rdata;
   assign bcast_match_o = s_q.bcast_match;
   assign cfg_o = s_q.cfg;
   assign reference_quick_charge_time_o = s_q.sleep_cfg[psfc_pkg::REF_QCHG_LSB +: 2];
   assign input_cap_quick_charge_time_o = s_q.shutdown_config[psfc_pkg::INPUT_CAP_QUICK_CHARGE_TIME_LSB +: 2];
   assign sleep_n_o = s_q.cfg.awake;
   assign ref_charging_o = s_q.ref_chg;
   assign incap_charging_o = s_q.incap_chg;
endmodule : psfc_cfg_regs

// File: shared/psfc_pkg.sv
package psfc_pkg;
   // register indices on the control bus
   localparam logic [7:0] SLEEP_SUPPLY_CONFIG_ADDR = 8'h02;
   localparam logic [7:0] SHUTDOWN_CONFIG_ADDR = 8'h05;
   localparam logic [7:0] SERIAL_FORMAT_CONFIG_ADDR = 8'h07;
   // reset values
   localparam logic [7:0] SLEEP_SUPPLY_CONFIG_RST = 8'h00;
   localparam logic [7:0] SHUTDOWN_CONFIG_RST = 8'h05;
   localparam logic [7:0] SERIAL_FORMAT_CONFIG_RST = 8'h30;
   // writable-bit masks; the rest read back their reset value
   localparam logic [7:0] SLEEP_SUPPLY_CONFIG_WMASK = 8'hFD;
   localparam logic [7:0] SHUTDOWN_CONFIG_WMASK = 8'h3F;
   localparam logic [7:0] SERIAL_FORMAT_CONFIG_WMASK = 8'hFF;
   // field positions
   localparam int RAIL_SEL_BIT = 7;
   localparam int REF_QCHG_LSB = 3;
   localparam int BCAST_EN_BIT = 2;
   localparam int AWAKE_BIT = 0;
   localparam int INPUT_CAP_QUICK_CHARGE_TIME_LSB = 4;
   localparam int PROTO_LSB = 6;
   localparam int WLEN_LSB = 4;
   localparam int FRAME_SYNC_POLARITY_BIT = 3;
   localparam int BIT_CLOCK_POLARITY_BIT = 2;
   localparam int TX_EDGE_BIT = 1;
   localparam int TX_FILL_BIT = 0;
   // broadcast target address
   localparam logic [6:0] BCAST_ADDR = 7'h4C;
   // quick-charge times in microseconds, clock rate in MHz
   localparam int CLK_MHZ = 10;
   localparam int REF_QCHG_US0 = 3500;
   localparam int REF_QCHG_US1 = 10000;
   localparam int REF_QCHG_US2 = 50000;
   localparam int REF_QCHG_US3 = 100000;
   localparam int INPUT_CAP_QUICK_CHARGE_TIME_US0 = 2500;
   localparam int INPUT_CAP_QUICK_CHARGE_TIME_US1 = 12500;
   localparam int INPUT_CAP_QUICK_CHARGE_TIME_US2 = 25000;
   localparam int INPUT_CAP_QUICK_CHARGE_TIME_US3 = 50000;
   localparam logic [23:0] REF_QCHG_CYC0 = 24'(REF_QCHG_US0 * CLK_MHZ);
   localparam logic [23:0] REF_QCHG_CYC1 = 24'(REF_QCHG_US1 * CLK_MHZ);
   localparam logic [23:0] REF_QCHG_CYC2 = 24'(REF_QCHG_US2 * CLK_MHZ);
   localparam logic [23:0] REF_QCHG_CYC3 = 24'(REF_QCHG_US3 * CLK_MHZ);
   localparam logic [23:0] INPUT_CAP_QUICK_CHARGE_TIME_CYC0 = 24'(INPUT_CAP_QUICK_CHARGE_TIME_US0 * CLK_MHZ);
   localparam logic [23:0] INPUT_CAP_QUICK_CHARGE_TIME_CYC1 = 24'(INPUT_CAP_QUICK_CHARGE_TIME_US1 * CLK_MHZ);
   localparam logic [23:0] INPUT_CAP_QUICK_CHARGE_TIME_CYC2 = 24'(INPUT_CAP_QUICK_CHARGE_TIME_US2 * CLK_MHZ);
   localparam logic [23:0] INPUT_CAP_QUICK_CHARGE_TIME_CYC3 = 24'(INPUT_CAP_QUICK_CHARGE_TIME_US3 * CLK_MHZ);

   typedef enum logic [1:0] {
      PSFC_PROTO_TDM = 2'h0,
      PSFC_PROTO_TWO_CH = 2'h1,
      PSFC_PROTO_LEFT_JUST = 2'h2,
      PSFC_PROTO_RSVD = 2'h3
   } psfc_proto_t;

   typedef struct packed {
      logic write;
      logic read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } psfc_req_t;

   typedef struct packed {
      logic analog_rail_source_sel;
      logic broadcast_address_enable;
      logic awake;
      psfc_proto_t serial_protocol_select;
      logic [5:0] serial_word_bits;
      logic frame_sync_polarity;
      logic bit_clock_polarity;
      logic tx_late_edge;
      logic tx_fill_hiz;
   } psfc_cfg_t;
endpackage : psfc_pkg

// File: hw/psfc_qchg_timer.sv
`timescale 1ns/1ns
// one-shot timer: runs for the selected duration after each start pulse
module psfc_qchg_timer #(
   parameter logic [23:0] CYC0 = 24'h000001,
   parameter logic [23:0] CYC1 = 24'h000001,
   parameter logic [23:0] CYC2 = 24'h000001,
   parameter logic [23:0] CYC3 = 24'h000001
) (
   input wire logic mclk_i,       // clock
   input wire logic resetn_i,     // async reset, low
   input wire logic start_i,      // start pulse
   input wire logic [1:0] sel_i,  // duration code
   output logic busy_o            // charge in progress
);
   typedef struct packed {
      logic [23:0] cnt;
      logic busy;
   } psfc_tmr_t;
   psfc_tmr_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      if (start_i) begin
         unique case (sel_i)
            2'h0: s_d.cnt = CYC0;
            2'h1: s_d.cnt = CYC1;
            2'h2: s_d.cnt = CYC2;
            2'h3: s_d.cnt = CYC3;
         endcase
         s_d.busy = 1'b1;
      end else if (s_q.busy) begin
         if (s_q.cnt <= 24'h000001) begin
            s_d.cnt = 24'h000000;
            s_d.busy = 1'b0;
         end else begin
            s_d.cnt = s_q.cnt - 24'h000001;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign busy_o = s_q.busy;
endmodule : psfc_qchg_timer

// File: testbench/psfc_cfg_regs_sva.sv
`timescale 1ns/1ns
module psfc_cfg_regs_sva (
   input wire logic mclk_i, // clock
   input wire logic resetn_i, // reset, low
   input wire psfc_pkg::psfc_req_t req_i, // access
   input wire logic [6:0] target_addr_i, // bus address
   input wire logic [7:0] rdata_o, // read data
   input wire logic bcast_match_o, // broadcast hit
   input wire psfc_pkg::psfc_cfg_t cfg_o, // decode
   input wire logic [1:0] reference_quick_charge_time_o, // ref code
   input wire logic [1:0] input_cap_quick_charge_time_o, // incap code
   input wire logic sleep_n_o, // awake
   input wire logic ref_charging_o, // ref charge
   input wire logic incap_charging_o // incap charge
);
   default clocking @(posedge mclk_i);
   endclocking
   default disable iff (!resetn_i);
   logic rd_sl, rd_sd, rd_fm, rd_um, wr_sl, wr_awake;
   assign rd_sl = req_i.read && !req_i.write && req_i.addr == psfc_pkg::SLEEP_SUPPLY_CONFIG_ADDR;
   assign rd_sd = req_i.read && !req_i.write && req_i.addr == psfc_pkg::SHUTDOWN_CONFIG_ADDR;
   assign rd_fm = req_i.read && req_i.addr == psfc_pkg::SERIAL_FORMAT_CONFIG_ADDR;
   assign rd_um = req_i.read && !(req_i.addr inside {8'h02, 8'h05, 8'h07});
   assign wr_sl = req_i.write && req_i.addr == psfc_pkg::SLEEP_SUPPLY_CONFIG_ADDR;
   assign wr_awake = req_i.wdata[psfc_pkg::AWAKE_BIT];
   a_bcast_flag: assert property (bcast_match_o == ($past(target_addr_i) == psfc_pkg::BCAST_ADDR
      && cfg_o.broadcast_address_enable)) else $error("broadcast match wrong");
   a_awake_follows: assert property ($past(wr_sl, 2) |-> sleep_n_o == $past(wr_awake, 2))
      else $error("awake output does not follow write");
   a_wlen_legal: assert property (cfg_o.serial_word_bits inside {6'h10, 6'h14, 6'h18, 6'h20})
      else $error("word length illegal");
   a_fmt_readback: assert property ($past(rd_fm) |-> rdata_o == {cfg_o.serial_protocol_select,
      ((cfg_o.serial_word_bits == 6'h20) ? 2'h3 : 2'((cfg_o.serial_word_bits - 6'h10) >> 2)),
      cfg_o.frame_sync_polarity, cfg_o.bit_clock_polarity,
      cfg_o.tx_late_edge, cfg_o.tx_fill_hiz}) else $error("format readback differs from decode");
   a_sleep_readback: assert property ($past(rd_sl) |-> rdata_o[7] == cfg_o.analog_rail_source_sel
      && rdata_o[4:3] == reference_quick_charge_time_o && rdata_o[2] == cfg_o.broadcast_address_enable
      && rdata_o[1:0] == {1'b0, cfg_o.awake}) else $error("sleep readback differs");
   a_shdn_readback: assert property ($past(rd_sd) |-> rdata_o[7:4] == {2'h0, input_cap_quick_charge_time_o})
      else $error("shutdown readback differs");
   a_unmapped_zero: assert property ($past(rd_um) |-> rdata_o == 8'h00) else $error("unmapped read not zero");
   a_charge_wake: assert property (($rose(ref_charging_o) || $rose(incap_charging_o)) |-> sleep_n_o)
      else $error("charge started while asleep");
   cover property (bcast_match_o);
   cover property ($rose(ref_charging_o));
   cover property ($past(rd_um));
endmodule : psfc_cfg_regs_sva
bind psfc_cfg_regs psfc_cfg_regs_sva u_psfc_cfg_regs_sva (.mclk_i(mclk_i), .resetn_i(resetn_i), .req_i(req_i),
   .target_addr_i(target_addr_i), .rdata_o(rdata_o), .bcast_match_o(bcast_match_o), .cfg_o(cfg_o),
   .reference_quick_charge_time_o(reference_quick_charge_time_o), .sleep_n_o(sleep_n_o),
   .input_cap_quick_charge_time_o(input_cap_quick_charge_time_o), .ref_charging_o(ref_charging_o),
   .incap_charging_o(incap_charging_o));

// File: testbench/psfc_host_model.sv
`timescale 1ns/1ns
module psfc_host_model #(
   parameter logic SUPPLY_3V3 = 1'b1
) (
   input wire logic mclk_i, // clock
   input wire logic [7:0] rdata_i, // read data
   output psfc_pkg::psfc_req_t req_o // access
);
   initial req_o = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      #1;
      if (!SUPPLY_3V3 && a == 8'h02) d[7] = 1'b0;
      if (a == 8'h02) d = d & 8'h9D;
      if (a == 8'h05) d[3:0] = 4'h5;
      if (a == 8'h07 && d[7:6] == 2'h3) d[7:6] = 2'h0;
      req_o = '{1'b1, 1'b0, a, d};
      @(posedge mclk_i);
      #1;
      req_o = '0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk_i);
      #1;
      req_o = '{1'b0, 1'b1, a, 8'h00};
      @(posedge mclk_i);
      #1;
      req_o = '0;
      d = rdata_i;
   endtask : rd
endmodule : psfc_host_model

// File: testbench/tb_psfc_cfg_regs.sv
`timescale 1ns/1ns
module tb_psfc_cfg_regs;
   logic mclk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [6:0] taddr = 7'h00;
   psfc_pkg::psfc_req_t req;
   psfc_pkg::psfc_cfg_t cfg;
   logic [7:0] rdata;
   logic [1:0] rcode, icode;
   logic bmatch, awake, rchg, ichg;
   int failures = 0;
   int checks = 0;
   always #50 mclk_i = ~mclk_i;
   psfc_host_model u_psfc_host_model (.mclk_i(mclk_i), .rdata_i(rdata), .req_o(req));
   psfc_cfg_regs u_psfc_cfg_regs (.mclk_i(mclk_i), .resetn_i(resetn_i), .req_i(req), .target_addr_i(taddr),
      .rdata_o(rdata), .bcast_match_o(bmatch), .cfg_o(cfg), .reference_quick_charge_time_o(rcode),
      .input_cap_quick_charge_time_o(icode), .sleep_n_o(awake), .ref_charging_o(rchg), .incap_charging_o(ichg));
   task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask : cmp
   task automatic summarize;
      if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_psfc_host_model.wr(a, d);
   endtask : wr
   task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      u_psfc_host_model.rd(a, v);
      cmp(n, e, v);
   endtask : rchk
   task automatic t_reset;
      rchk("sleep", 8'h02, 8'h00);
      rchk("shdn", 8'h05, 8'h05);
      rchk("fmt", 8'h07, 8'h30);
      cmp("awake", 8'h00, {7'h0, awake});
      cmp("wbits", 8'h20, {2'h0, cfg.serial_word_bits});
   endtask : t_reset
   task automatic t_wake;
      int n;
      wr(8'h02, 8'h85);
      rchk("sleep", 8'h02, 8'h85);
      cmp("cfg", 8'h07, {5'h0, cfg.analog_rail_source_sel, cfg.broadcast_address_enable, cfg.awake});
      for (n = 0; n < 10 && rchg !== 1'b1; n++) #100;
      cmp("incap on", 8'h01, {7'h0, ichg});
      for (n = 0; n < 40000 && ichg === 1'b1; n++) #100;
      cmp("incap time", 8'h01, {7'h0, n > 24990 && n < 25010});
      for (n = n; n < 40000 && rchg === 1'b1; n++) #100;
      cmp("ref time", 8'h01, {7'h0, n > 34990 && n < 35010});
      cmp("incap off", 8'h00, {7'h0, ichg});
      wr(8'h02, 8'h9D);
      rchk("sleep", 8'h02, 8'h9D);
      cmp("rcode", 8'h03, {6'h0, rcode});
      cmp("no restart", 8'h00, {7'h0, rchg});
   endtask : t_wake
   task automatic t_bcast;
      taddr = 7'h4C;
      #100;
      cmp("match", 8'h01, {7'h0, bmatch});
      taddr = 7'h4D;
      #100;
      cmp("other", 8'h00, {7'h0, bmatch});
      wr(8'h02, 8'h81);
      taddr = 7'h4C;
      #200;
      cmp("disabled", 8'h00, {7'h0, bmatch});
   endtask : t_bcast
   task automatic t_regs;
      wr(8'h05, 8'hFF);
      rchk("shdn", 8'h05, 8'h35);
      cmp("icode", 8'h03, {6'h0, icode});
      wr(8'h03, 8'hFF);
      rchk("unmapped", 8'h03, 8'h00);
   endtask : t_regs
   task automatic t_fmt;
      logic [7:0] d;
      logic [5:0] wb [4] = '{6'h10, 6'h14, 6'h18, 6'h20};
      for (int i = 0; i < 12; i++) begin
         d = {2'(i / 4), 2'(i % 4), (i % 2) ? 4'hA : 4'h5};
         wr(8'h07, d);
         rchk("fmt", 8'h07, d);
         cmp("proto", {6'h0, d[7:6]}, {6'h0, cfg.serial_protocol_select});
         cmp("wbits", {2'h0, wb[i % 4]}, {2'h0, cfg.serial_word_bits});
         cmp("pol", {4'h0, d[3:0]}, {4'h0, cfg.frame_sync_polarity, cfg.bit_clock_polarity,
            cfg.tx_late_edge, cfg.tx_fill_hiz});
      end
      wr(8'h07, 8'hF0);
      rchk("fmt", 8'h07, 8'h30);
   endtask : t_fmt
   initial begin
      repeat (5) @(posedge mclk_i);
      #1;
      resetn_i = 1'b1;
      t_reset;
      t_wake;
      t_bcast;
      t_regs;
      t_fmt;
      summarize;
   end
   initial begin
      #6000000;
      failures++;
      summarize;
   end
endmodule : tb_psfc_cfg_regs
